// *** src/rls_pkg.sv ***
// rls_pkg: constants, register map and carrier types of the receive
// lock and signal alarm block.
// assumes: level codes come from an 8-bit converter whose full scale is
// the reference voltage.
package rls_pkg;

  // level codes
  localparam int            LVL_W      = 8;
  localparam logic [7:0]    VREF_CODE  = 8'hFF; // level tied to reference
  localparam logic [7:0]    VREF40     = 8'h66; // 0.4 x reference
  localparam logic [7:0]    HYST_CODE  = 8'h04; // alarm clear margin
  localparam int            LOS_K_ABS  = 958;   // per mille, absolute
  localparam int            LOS_K_PROP = 610;   // per mille, proportional
  localparam int            SLC_K_ABS  = 375;   // per mille
  localparam int            SLC_K_PROP = 950;   // per mille
  localparam int            SLC_OFS    = 1;     // 5 mV in codes
  localparam int            SLC_PROP_O = 30;    // per mille of amplitude
  localparam int            PH_PS_PER_V = 85;
  localparam int            CODE_PER_V = 204;   // 255 codes per 1.25 V

  // timing
  localparam int            SYS_CLK_MHZ    = 50;
  localparam int            REF_TIMEOUT_NS = 1000;
  localparam int            REF_TIMEOUT_CYC =
    (REF_TIMEOUT_NS * SYS_CLK_MHZ) / 1000;

  // lock window, counted in reference edges
  localparam int            CNT_W      = 17;
  localparam int            WIN_EDGES  = 65536;
  localparam int            LOL_PPM    = 732;
  localparam int            LOCK_PPM   = 366;
  localparam int            LOL_DIFF   = (WIN_EDGES * LOL_PPM) / 1000000;
  localparam int            LOCK_DIFF  = (WIN_EDGES * LOCK_PPM) / 1000000;

  // register map
  localparam logic [7:0]    REG_STATUS = 8'h00;
  localparam logic [7:0]    REG_EVENT  = 8'h04;
  localparam logic [7:0]    REG_CLEAR  = 8'h08;
  localparam logic [7:0]    REG_ENABLE = 8'h0C;
  localparam logic [7:0]    REG_COUNT  = 8'h10;
  localparam int            EV_W       = 4;
  localparam int            EV_LOS     = 0;
  localparam int            EV_LOL     = 1;
  localparam int            EV_LOCK    = 2;
  localparam int            EV_REFLOST = 3;
  localparam logic [3:0]    ENABLE_RST = 4'h0;

  typedef enum logic {RLS_UNLOCKED, RLS_LOCKED} rls_lock_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rls_bus_req_t;

  typedef struct packed {
    logic [7:0] amp;      // amplitude monitor, half of pk-pk
    logic [7:0] lossThr;  // loss_threshold_level
    logic [7:0] sliceThr; // decision_threshold_level
    logic [7:0] phaseThr; // sample_offset_level
  } rls_levels_t;

endpackage : rls_pkg

// *** src/rls_sync.sv ***
// rls_sync: two-flop synchroniser for a group of pins, with rise pulses.
// assumes: pins are asynchronous to sys_clk; multi-bit codes are quasi
// static, so a code may be seen mixed for one cycle while it moves.
`timescale 1ns/100ps
`default_nettype none
module rls_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk, // system clock
  input  wire logic         rstn,    // async reset, active low
  input  wire logic [W-1:0] pinIn,   // raw pins
  output logic      [W-1:0] level,   // synchronised level
  output logic      [W-1:0] rise     // one-cycle pulse on rising edge
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] last;
  } rls_sync_st_t;

  rls_sync_st_t st;
  rls_sync_st_t next_st;

  ////////////////////////////////////////////////////////////////////
  // meta is read only by stable, never by the edge logic
  always_comb begin
    next_st        = st;
    next_st.meta   = pinIn;
    next_st.stable = st.meta;
    next_st.last   = st.stable;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.stable;
  assign rise  = st.stable & ~st.last;

endmodule : rls_sync
`default_nettype wire

// *** src/rls_supervisor.sv ***
// rls_supervisor: receive lock detector and loss-of-signal alarm.
// assumes: reference and divided recovered clocks are far below 25 MHz
// so each high and low phase spans at least two sys_clk periods; level
// inputs are converter codes.
//
// Behaviour
// - alarm below threshold, with hysteresis
// - loss threshold at reference disables alarm
// - scaling select picks absolute or proportional mapping
// - decision threshold at reference gives zero slice
// - default sampling at bit centre
// - offset level at reference gives zero offset
// - compare divided recovered clock against reference
// - source select picks reference or transmit clock
// - beyond out limit declare lock lost, reacquire
// - recovered clock wanders while lock lost unless held to reference
// - lock lost held until within into limit
// - no valid reference forces lock lost
// - alarm forces lock lost unless held
// - out-of-lock near 732 ppm, within 610..860
// - into lock at 366 ppm, by 240
// - hold mode tracks reference, not data
`timescale 1ns/100ps
`default_nettype none
module rls_supervisor #(
  parameter int WIN = rls_pkg::WIN_EDGES // window in reference edges
) (
  input  wire logic                 sys_clk,        // 50 MHz clock
  input  wire logic                 rstn,           // async reset, low
  input  wire rls_pkg::rls_bus_req_t busReq,        // register request
  output logic [31:0]               busRdata,       // read data
  output logic                      irq,            // level interrupt
  input  wire rls_pkg::rls_levels_t levels,         // level codes
  input  wire logic                 refClkIn,       // reference_clock_in
  input  wire logic                 txParClkIn,     // tx parallel clock
  input  wire logic                 recDivClk,      // divided recovered
  input  wire logic                 sliceScaleSel,  // 1 proportional
  input  wire logic                 refSourceSel,   // 1 reference clock
  input  wire logic                 holdToRefN,     // hold, active low
  output logic                      lossAlarmN,     // signal loss, low
  output logic                      rxLockLostN,    // lock lost, low
  output logic [7:0]                sliceOffset,    // signed codes
  output logic [7:0]                phaseOffsetPs,  // signed ps
  output logic                      cdrTrackRef,    // clock on reference
  output logic                      wanderAllowed   // reacquiring on data
);
  import rls_pkg::*;

  localparam logic [CNT_W-1:0] WIN_LAST  = CNT_W'(WIN - 1);
  localparam logic [CNT_W-1:0] WIN_C     = CNT_W'(WIN);
  localparam logic [CNT_W-1:0] LOL_C     = CNT_W'((WIN * LOL_PPM) / 1000000);
  localparam logic [CNT_W-1:0] LOCK_C    = CNT_W'((WIN * LOCK_PPM) / 1000000);
  localparam logic [7:0]       TO_LAST   = 8'(REF_TIMEOUT_CYC - 1);

  typedef struct packed {
    rls_lock_t        lockSt;
    logic             refValid;
    logic             alarm;
    logic [CNT_W-1:0] refCnt;
    logic [CNT_W-1:0] recCnt;
    logic [CNT_W-1:0] lastRec;
    logic [7:0]       toCnt;
    logic [EV_W-1:0]  events;
    logic [EV_W-1:0]  enable;
    logic [31:0]      rdata;
    logic             irq;
    logic             alarmN;
    logic             lockLostN;
    logic [7:0]       slice;
    logic [7:0]       phase;
    logic             trackRef;
    logic             wander;
  } rls_state_t;

  rls_state_t st;
  rls_state_t next_st;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers; clocks and straps first, level codes second
  logic [5:0]  pinLvl;
  logic [5:0]  pinRise;
  logic [31:0] lvlSync;

  // hold strap enters inverted so the cleared flops read as not held;
  // a plain copy would show a false hold for two cycles after reset
  rls_sync #(.W(6)) u_pins (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .pinIn   ({~holdToRefN, refSourceSel, sliceScaleSel,
               recDivClk, txParClkIn, refClkIn}),
    .level   (pinLvl),
    .rise    (pinRise)
  );

  rls_sync #(.W(32)) u_levels (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .pinIn   (levels),
    .level   (lvlSync),
    .rise    ()
  );

  rls_levels_t lv;
  logic        propMode;
  logic        useRefClk;
  logic        holdN;
  logic        refEdge;
  logic        recEdge;

  assign lv        = rls_levels_t'(lvlSync);
  assign propMode  = pinLvl[3];
  assign useRefClk = pinLvl[4];
  assign holdN     = ~pinLvl[5];
  assign recEdge   = pinRise[2];
  // transmit clock serves when the dedicated reference is not chosen
  assign refEdge   = useRefClk ? pinRise[0] : pinRise[1];

  ////////////////////////////////////////////////////////////////////
  // analog mappings, computed in integers then cut to 8-bit codes
  int losK;
  int assertLvl;
  int clearLvl;
  int sliceD;
  int sliceV;
  int phaseD;
  int phaseV;

  always_comb begin
    losK      = propMode ? LOS_K_PROP : LOS_K_ABS;
    assertLvl = (int'(lv.lossThr) * losK) / 1000;
    clearLvl  = assertLvl + int'(HYST_CODE);
    sliceD    = int'(lv.sliceThr) - int'(VREF40);
    if (propMode) begin
      sliceV = ((sliceD * int'(lv.amp) * SLC_K_PROP) / 1000) / 256
             - (int'(lv.amp) * SLC_PROP_O) / 1000;
    end else begin
      sliceV = (sliceD * SLC_K_ABS) / 1000 - SLC_OFS;
    end
    phaseD = int'(lv.phaseThr) - int'(VREF40);
    phaseV = (phaseD * PH_PS_PER_V) / CODE_PER_V;
  end

  ////////////////////////////////////////////////////////////////////
  // lock window arithmetic: edges seen in the closing cycle count too
  logic [CNT_W-1:0] recFinal;
  logic [CNT_W-1:0] freqDiff;
  logic             winEnd;

  always_comb begin
    recFinal = st.recCnt + CNT_W'(recEdge);
    freqDiff = (recFinal > WIN_C) ? recFinal - WIN_C : WIN_C - recFinal;
    winEnd   = refEdge && (st.refCnt == WIN_LAST);
  end

  ////////////////////////////////////////////////////////////////////
  // next state of the whole block
  logic [EV_W-1:0] evSet;
  logic [EV_W-1:0] evClr;
  logic            lolNow;

  always_comb begin
    next_st = st;
    evSet   = '0;
    evClr   = '0;

    // signal loss alarm with hysteresis, or forced off when disabled
    if (lv.lossThr == VREF_CODE) begin
      next_st.alarm = 1'b0;
    end else if (!st.alarm && int'(lv.amp) < assertLvl) begin
      next_st.alarm = 1'b1;
    end else if (st.alarm && int'(lv.amp) > clearLvl) begin
      next_st.alarm = 1'b0;
    end
    if (next_st.alarm && !st.alarm) begin
      evSet[EV_LOS] = 1'b1;
    end

    // reference presence watchdog
    if (refEdge) begin
      next_st.toCnt    = '0;
      next_st.refValid = 1'b1;
    end else if (st.toCnt == TO_LAST) begin
      next_st.refValid = 1'b0;
    end else begin
      next_st.toCnt = st.toCnt + 8'h01;
    end
    if (st.refValid && !next_st.refValid) begin
      evSet[EV_REFLOST] = 1'b1;
    end

    // frequency comparison over a window of reference edges
    if (!next_st.refValid) begin
      next_st.refCnt = '0;
      next_st.recCnt = '0;
      next_st.lockSt = RLS_UNLOCKED;
    end else if (winEnd) begin
      next_st.refCnt  = '0;
      next_st.recCnt  = '0;
      next_st.lastRec = recFinal;
      case (st.lockSt)
        RLS_LOCKED: begin
          if (freqDiff > LOL_C) begin
            next_st.lockSt = RLS_UNLOCKED;
          end
        end
        RLS_UNLOCKED: begin
          if (freqDiff <= LOCK_C) begin
            next_st.lockSt = RLS_LOCKED;
          end
        end
        default: next_st.lockSt = RLS_UNLOCKED;
      endcase
    end else begin
      if (refEdge) begin
        next_st.refCnt = st.refCnt + CNT_W'(1);
      end
      next_st.recCnt = recFinal;
    end
    if (next_st.lockSt == RLS_LOCKED && st.lockSt == RLS_UNLOCKED) begin
      evSet[EV_LOCK] = 1'b1;
    end

    // lock lost: out of lock, no reference, or alarm while not held
    lolNow = (next_st.lockSt == RLS_UNLOCKED) || !next_st.refValid
           || (next_st.alarm && holdN);
    next_st.lockLostN = !lolNow;
    if (lolNow && st.lockLostN) begin
      evSet[EV_LOL] = 1'b1;
    end
    next_st.alarmN = !next_st.alarm;

    // hold to reference steers the recovered clock onto the reference
    next_st.trackRef = !holdN;
    next_st.wander   = lolNow && holdN;

    // slice and sample offsets; zero means centre of the eye
    if (lv.sliceThr == VREF_CODE) begin
      next_st.slice = 8'h00;
    end else begin
      next_st.slice = 8'(sliceV);
    end
    if (lv.phaseThr == VREF_CODE) begin
      next_st.phase = 8'h00;
    end else begin
      next_st.phase = 8'(phaseV);
    end

    // register writes; clear and enable are the only writable ones
    if (busReq.wr) begin
      if (busReq.addr == REG_CLEAR) begin
        evClr = busReq.wdata[EV_W-1:0];
      end else if (busReq.addr == REG_ENABLE) begin
        next_st.enable = busReq.wdata[EV_W-1:0];
      end
    end
    // a set in the clearing cycle wins so no event is lost
    next_st.events = (st.events & ~evClr) | evSet;
    next_st.irq    = |(next_st.events & next_st.enable);

    // register reads answer in the next cycle, zero when idle
    next_st.rdata = 32'h0000_0000;
    if (busReq.rd) begin
      if (busReq.addr == REG_STATUS) begin
        next_st.rdata = {27'h0, !holdN,
                         st.lockSt == RLS_LOCKED, st.refValid,
                         !st.lockLostN, st.alarm};
      end else if (busReq.addr == REG_EVENT) begin
        next_st.rdata = {28'h0, st.events};
      end else if (busReq.addr == REG_ENABLE) begin
        next_st.rdata = {28'h0, st.enable};
      end else if (busReq.addr == REG_COUNT) begin
        next_st.rdata = {15'h0, st.lastRec};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // single state register; lock lost shows from reset until locked
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st           <= '0;
      st.lockSt    <= RLS_UNLOCKED;
      st.enable    <= ENABLE_RST;
      st.alarmN    <= 1'b1;
      st.lockLostN <= 1'b0;
      st.wander    <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign busRdata      = st.rdata;
  assign irq           = st.irq;
  assign lossAlarmN    = st.alarmN;
  assign rxLockLostN   = st.lockLostN;
  assign sliceOffset   = st.slice;
  assign phaseOffsetPs = st.phase;
  assign cdrTrackRef   = st.trackRef;
  assign wanderAllowed = st.wander;

endmodule : rls_supervisor
`default_nettype wire

// *** sim/rls_supervisor_sva.sv ***
// rls_supervisor_sva: port checks of the lock and alarm supervisor.
// assumes: bound to rls_supervisor, sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module rls_supervisor_sva #(
  parameter int WIN = rls_pkg::WIN_EDGES // window in reference edges
) (
  input wire logic                  sys_clk,       // clock
  input wire logic                  rstn,          // reset, low
  input wire rls_pkg::rls_bus_req_t busReq,        // bus request
  input wire logic [31:0]           busRdata,      // read data
  input wire logic                  irq,           // interrupt
  input wire rls_pkg::rls_levels_t  levels,        // level codes
  input wire logic                  refClkIn,      // reference
  input wire logic                  txParClkIn,    // tx clock
  input wire logic                  recDivClk,     // recovered
  input wire logic                  sliceScaleSel, // scaling
  input wire logic                  refSourceSel,  // source
  input wire logic                  holdToRefN,    // hold, low
  input wire logic                  lossAlarmN,    // alarm, low
  input wire logic                  rxLockLostN,   // lock lost, low
  input wire logic [7:0]            sliceOffset,   // slice
  input wire logic [7:0]            phaseOffsetPs, // phase
  input wire logic                  cdrTrackRef,   // on reference
  input wire logic                  wanderAllowed  // reacquiring
);
  import rls_pkg::*;
  localparam int QUIET_MAX = REF_TIMEOUT_CYC + 8; // sync and margin
  logic       prevRef;
  logic       prevSel;
  logic [7:0] quietCyc;
  // cycles since the selected reference last moved; margin is lenient
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prevRef  <= 1'b0;
      prevSel  <= 1'b0;
      quietCyc <= 8'h00;
    end else begin
      prevRef <= refSourceSel ? refClkIn : txParClkIn;
      prevSel <= refSourceSel;
      if (prevRef != (refSourceSel ? refClkIn : txParClkIn) ||
          prevSel != refSourceSel) quietCyc <= 8'h00;
      else if (quietCyc != 8'hFF) quietCyc <= quietCyc + 8'h01;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_alarm_forces_lost: assert property (
    (!lossAlarmN && !cdrTrackRef)[*3] |-> !rxLockLostN)
    else $error("lock flag high during alarm");
  a_hold_sets_track: assert property (
    (!holdToRefN)[*4] |-> cdrTrackRef) else $error("hold not tracked");
  a_free_clears_track: assert property (
    holdToRefN[*4] |-> !cdrTrackRef) else $error("hold stuck on");
  a_locked_no_wander: assert property (
    rxLockLostN[*2] |-> !wanderAllowed) else $error("wander while locked");
  a_hold_no_wander: assert property (
    cdrTrackRef[*2] |-> !wanderAllowed) else $error("wander while held");
  a_loss_off_ref: assert property (
    (levels.lossThr == VREF_CODE)[*5] |-> lossAlarmN)
    else $error("alarm with detection off");
  a_slice_zero_ref: assert property (
    (levels.sliceThr == VREF_CODE)[*5] |-> sliceOffset == 8'h00)
    else $error("slice not zero");
  a_phase_zero_ref: assert property (
    (levels.phaseThr == VREF_CODE)[*5] |-> phaseOffsetPs == 8'h00)
    else $error("phase offset not zero");
  a_ref_quiet_lost: assert property (
    quietCyc > QUIET_MAX |-> !rxLockLostN)
    else $error("locked without reference");
  a_rdata_idle_zero: assert property (
    !$past(busReq.rd) |-> busRdata == 32'h0)
    else $error("read data outside read slot");
endmodule : rls_supervisor_sva
bind rls_supervisor rls_supervisor_sva #(.WIN(WIN)) rls_supervisor_sva_inst (
  .sys_clk(sys_clk), .rstn(rstn), .busReq(busReq), .busRdata(busRdata),
  .irq(irq), .levels(levels), .refClkIn(refClkIn),
  .txParClkIn(txParClkIn), .recDivClk(recDivClk),
  .sliceScaleSel(sliceScaleSel), .refSourceSel(refSourceSel),
  .holdToRefN(holdToRefN), .lossAlarmN(lossAlarmN),
  .rxLockLostN(rxLockLostN), .sliceOffset(sliceOffset),
  .phaseOffsetPs(phaseOffsetPs), .cdrTrackRef(cdrTrackRef),
  .wanderAllowed(wanderAllowed));
`default_nettype wire

// *** sim/rls_front_end_model.sv ***
// rls_front_end_model: line side, amplitude and divided recovered clock.
// assumes: clock derived from sys_clk, so its rate is exact.
`timescale 1ns/100ps
`default_nettype none
module rls_front_end_model (
  input  wire logic       sys_clk,   // system clock
  input  wire logic       rstn,      // reset, low
  input  wire logic [3:0] halfCyc,   // half period, 0 stands still
  input  wire logic [7:0] ampSet,    // amplitude asked of the line
  output logic            recDivClk, // divided recovered clock
  output logic [7:0]      amp        // amplitude monitor code
);
  logic [3:0] cnt;
  // a stopped clock holds its level rather than running free
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt       <= 4'h0;
      recDivClk <= 1'b0;
      amp       <= 8'h00;
    end else begin
      amp <= ampSet;
      cnt <= (cnt + 4'h1 >= halfCyc) ? 4'h0 : cnt + 4'h1;
      if (halfCyc != 4'h0 && cnt + 4'h1 >= halfCyc) recDivClk <= ~recDivClk;
    end
  end
endmodule : rls_front_end_model
`default_nettype wire

// *** sim/rls_supervisor_tb_top.sv ***
// rls_supervisor_tb_top: scenario tests of the supervisor.
// assumes: checker bound; short lock window needs exact count match.
`timescale 1ns/100ps
`default_nettype none
module rls_supervisor_tb_top;
  import rls_pkg::*;
  localparam int WIN_SIM = 1024;
  logic         sys_clk, rstn, irq, refClkIn, txParClkIn, recDivClk;
  logic         sliceScaleSel, refSourceSel, holdToRefN, lossAlarmN;
  logic         rxLockLostN, cdrTrackRef, wanderAllowed, refRun, txRun;
  logic [7:0]   sliceOffset, phaseOffsetPs, feAmp, ampSet;
  logic [7:0]   lossThr, sliceThr, phaseThr;
  logic [31:0]  busRdata;
  logic [3:0]   recHalf;
  rls_bus_req_t busReq;
  rls_levels_t  levels;
  int           n_mismatch, checks, cyc, refCnt;
  assign levels = '{amp: feAmp, lossThr: lossThr, sliceThr: sliceThr,
                    phaseThr: phaseThr};
  rls_supervisor #(.WIN(WIN_SIM)) rls_supervisor_inst (
    .sys_clk(sys_clk), .rstn(rstn), .busReq(busReq), .busRdata(busRdata),
    .irq(irq), .levels(levels), .refClkIn(refClkIn),
    .txParClkIn(txParClkIn), .recDivClk(recDivClk),
    .sliceScaleSel(sliceScaleSel), .refSourceSel(refSourceSel),
    .holdToRefN(holdToRefN), .lossAlarmN(lossAlarmN),
    .rxLockLostN(rxLockLostN), .sliceOffset(sliceOffset),
    .phaseOffsetPs(phaseOffsetPs), .cdrTrackRef(cdrTrackRef),
    .wanderAllowed(wanderAllowed));
  rls_front_end_model rls_front_end_model_inst (.sys_clk(sys_clk),
    .rstn(rstn), .halfCyc(recHalf), .ampSet(ampSet),
    .recDivClk(recDivClk), .amp(feAmp));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // reference clocks: half period of three cycles, stoppable
  always @(posedge sys_clk) begin
    cyc    <= cyc + 1;
    refCnt <= (refCnt == 2) ? 0 : refCnt + 1;
    if (refRun && refCnt == 2) refClkIn <= ~refClkIn;
    if (txRun && refCnt == 2) txParClkIn <= ~txParClkIn;
    if (cyc == 90000) begin
      n_mismatch++;
      print_verdict;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk) busReq <= '0;
  endtask : bus_wr
  // data stand only in the cycle after the read edge
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk) busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0,
                                   rd: 1'b1};
    @(posedge sys_clk) busReq <= '0;
    #1 d = busRdata;
  endtask : bus_rd
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle
  task automatic wait_lost(input logic val, input int limit);
    int i;
    i = 0;
    while (rxLockLostN !== val && i < limit) begin
      settle(1);
      i++;
    end
  endtask : wait_lost
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    logic [31:0] rd;
    check(rxLockLostN, 1'b0);
    check(lossAlarmN, 1'b1);
    check(wanderAllowed, 1'b1);
    check(irq, 1'b0);
    @(posedge sys_clk) rstn <= 1'b1;
    bus_rd(REG_ENABLE, rd);
    check(cdrTrackRef, 1'b0);
    check(rd, {28'h0, ENABLE_RST});
    bus_wr(REG_STATUS, 32'hFFFF_FFFF);
    bus_rd(8'h20, rd);
    check(rd, 32'h0);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_lock;
    logic [31:0] rd;
    @(posedge sys_clk) refRun <= 1'b1;
    wait_lost(1'b1, 25000);
    check(rxLockLostN, 1'b1);
    check(wanderAllowed, 1'b0);
    bus_rd(REG_EVENT, rd);
    check(rd[EV_LOCK], 1'b1);
    // equal clocks give exactly one recovered edge per reference edge
    bus_rd(REG_COUNT, rd);
    check(rd, 32'(WIN_SIM));
    // not held, locked, reference valid, lock not lost, no alarm
    bus_rd(REG_STATUS, rd);
    check(rd, 32'h0000_000C);
    bus_wr(REG_ENABLE, 32'h4);
    settle(2);
    check(irq, 1'b1);
    bus_wr(REG_CLEAR, 32'h4);
    settle(2);
    check(irq, 1'b0);
    $display("test_lock done");
  endtask : test_lock
  task automatic test_unlock;
    logic [31:0] rd;
    @(posedge sys_clk) recHalf <= 4'h4;
    wait_lost(1'b0, 15000);
    check(rxLockLostN, 1'b0);
    check(wanderAllowed, 1'b1);
    bus_rd(REG_EVENT, rd);
    check(rd[EV_LOL], 1'b1);
    @(posedge sys_clk) recHalf <= 4'h3;
    settle(100);
    check(rxLockLostN, 1'b0);
    wait_lost(1'b1, 20000);
    check(rxLockLostN, 1'b1);
    $display("test_unlock done");
  endtask : test_unlock
  // abs threshold 0x80 is 122 codes, clear above 126; prop is 78
  task automatic test_alarm;
    @(posedge sys_clk) lossThr <= 8'h80;
    ampSet <= 8'h5A;
    settle(8);
    check(lossAlarmN, 1'b0);
    check(rxLockLostN, 1'b0);
    @(posedge sys_clk) holdToRefN <= 1'b0;
    settle(8);
    check(cdrTrackRef, 1'b1);
    wait_lost(1'b1, 100);
    check(rxLockLostN, 1'b1);
    @(posedge sys_clk) holdToRefN <= 1'b1;
    ampSet <= 8'h7C;
    settle(8);
    check(lossAlarmN, 1'b0);
    @(posedge sys_clk) ampSet <= 8'h7F;
    settle(8);
    check(lossAlarmN, 1'b1);
    @(posedge sys_clk) sliceScaleSel <= 1'b1;
    ampSet <= 8'h5A;
    settle(8);
    check(lossAlarmN, 1'b1);
    @(posedge sys_clk) ampSet <= 8'h40;
    settle(8);
    check(lossAlarmN, 1'b0);
    @(posedge sys_clk) lossThr <= VREF_CODE;
    settle(8);
    check(lossAlarmN, 1'b1);
    $display("test_alarm done");
  endtask : test_alarm
  task automatic test_reference_source_select;
    logic [31:0] rd;
    @(posedge sys_clk) refRun <= 1'b0;
    settle(100);
    check(rxLockLostN, 1'b0);
    bus_rd(REG_EVENT, rd);
    check(rd[EV_REFLOST], 1'b1);
    @(posedge sys_clk) refSourceSel <= 1'b0;
    txRun <= 1'b1;
    wait_lost(1'b1, 25000);
    check(rxLockLostN, 1'b1);
    $display("test_reference_source_select done");
  endtask : test_reference_source_select
  task automatic test_levels;
    check(phaseOffsetPs, 8'h00);
    @(posedge sys_clk) sliceThr <= VREF_CODE;
    phaseThr <= VREF_CODE;
    settle(8);
    check(sliceOffset, 8'h00);
    check(phaseOffsetPs, 8'h00);
    @(posedge sys_clk) sliceThr <= 8'hFE;
    phaseThr <= 8'hFE;
    settle(8);
    check(sliceOffset != 8'h00, 1'b1);
    // 152 codes above 0.4 x reference: 0.745 V, 85 ps/V gives 63 ps
    check(phaseOffsetPs, 8'h3F);
    // absolute slicing: 152 x 0.375 = 57 codes, less 5 mV of one code
    @(posedge sys_clk) sliceScaleSel <= 1'b0;
    settle(8);
    check(sliceOffset, 8'h38);
    $display("test_levels done");
  endtask : test_levels
  initial begin
    {rstn, refClkIn, txParClkIn, sliceScaleSel, refRun, txRun} = '0;
    {cyc, refCnt, n_mismatch, checks} = '0;
    busReq = '0;
    refSourceSel = 1'b1;
    holdToRefN = 1'b1;
    ampSet = 8'h60;
    lossThr = VREF_CODE;
    sliceThr = VREF40;
    phaseThr = VREF40;
    recHalf = 4'h3;
    repeat (10) @(posedge sys_clk);
    test_reset;
    test_lock;
    test_unlock;
    test_alarm;
    test_reference_source_select;
    test_levels;
    print_verdict;
  end
endmodule : rls_supervisor_tb_top
`default_nettype wire
